// ---- design/safe_out_pkg.sv ----
// constants, encodings and helpers for the safety output test pulse block
// Notes on behaviour
// RULE1: four output channels, each driven by its own selected status signal.
// RULE2: each channel drives its selected signal on two legs, A and B.
// RULE3: channel four pairs a sinking leg with a sourcing leg.
// RULE4: one status signal may feed several channels at once.
// RULE5: enabled, active channels get periodic brief off-pulses for diagnosis.
// RULE6: leg A and leg B pulses never overlap in time.
// RULE7: every off-pulse lasts the shared configurable off-time; the code clamps it to 1 .. half period minus one.
// RULE8: software picks an off-time short enough for the load to ignore.
// RULE9: test pulsing is enabled separately per channel.
// RULE10: a diagnosed fault raises the output fault alarm.
// RULE11: all channels stay off until start-up diagnosis completes.
// RULE12: a speed-monitor-disabling alarm forces every channel off.
// RULE13: other alarms leave all channels driving their signals.
// RULE14: pulsed leg must read low and the partner leg high, else fault.
// RULE15: selection codes pick one of ten sources or none (channel off).
package safe_out_pkg;
   localparam int CH_COUNT = 4;
   localparam int LEG_COUNT = 8;
   localparam int SRC_COUNT = 10;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int SEL_W = 4;
   localparam int IRQ_W = 5;
   // register byte offsets
   localparam logic [7:0] OFS_OUT_SEL = 8'h00;
   localparam logic [7:0] OFS_PULSE_EN = 8'h04;
   localparam logic [7:0] OFS_OFF_TIME = 8'h08;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
   localparam logic [7:0] OFS_IRQ_CLR = 8'h10;
   localparam logic [7:0] OFS_IRQ_EN = 8'h14;
   localparam logic [7:0] OFS_STATE = 8'h18;
   // reset values
   localparam logic [15:0] OUT_SEL_RST = 16'h0000;
   localparam logic [3:0] PULSE_EN_RST = 4'h0;
   localparam logic [15:0] OFF_TIME_RST = 16'h000A;
   localparam logic [4:0] IRQ_EN_RST = 5'h00;
   // status and state fields
   localparam int IRQ_FORCED_OFF = 4;
   localparam int STATE_RUN_BIT = 8;
   localparam int STATE_FAULT_BIT = 9;
   // selection codes
   localparam logic [3:0] SEL_NONE = 4'h0;
   localparam logic [3:0] SEL_STO = 4'h1;
   localparam logic [3:0] SEL_SS1 = 4'h2;
   localparam logic [3:0] SEL_SS2 = 4'h3;
   localparam logic [3:0] SEL_SLS1 = 4'h4;
   localparam logic [3:0] SEL_SLS2 = 4'h5;
   localparam logic [3:0] SEL_SLS3 = 4'h6;
   localparam logic [3:0] SEL_SLS4 = 4'h7;
   localparam logic [3:0] SEL_SPD_MON = 4'h8;
   localparam logic [3:0] SEL_SOS = 4'h9;
   localparam logic [3:0] SEL_SBC = 4'hA;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // timing: off-time counts in 1 us ticks
   localparam int CLK_PERIOD_NS = 4;
   localparam int OFF_UNIT_NS = 1000;
   localparam int TICK_CYC = OFF_UNIT_NS / CLK_PERIOD_NS;
   localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);
   localparam logic [15:0] PERIOD_TICKS_DEF = 16'h03E8;

   function automatic logic srcPick(input logic [3:0] sel,
                                    input logic [SRC_COUNT-1:0] src);
      logic [3:0] idx;
      idx = sel - SEL_STO;
      srcPick = (sel >= SEL_STO && sel <= SEL_SBC) ? src[idx] : 1'b0;
   endfunction

   function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = data[8*b +: 8];
         end
      end
      mergeBytes = res;
   endfunction
endpackage

// ---- design/feedback_sync.sv ----
// two-flop synchroniser for the leg read-back pins
`timescale 1ns/1ps
module feedback_sync (
   input wire logic ref_clk, // core clock
   input wire logic reset_n, // synchronous reset, active low
   input wire logic [safe_out_pkg::LEG_COUNT-1:0] asyncIn, // raw pins
   output logic [safe_out_pkg::LEG_COUNT-1:0] syncOut // synchronised
);
   import safe_out_pkg::*;
   typedef struct packed {
      logic [LEG_COUNT-1:0] stage1;
      logic [LEG_COUNT-1:0] stage2;
   } sync_t;
   sync_t s;
   sync_t n;

   always_comb begin
      n = s;
      n.stage1 = asyncIn;
      n.stage2 = s.stage1;
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign syncOut = s.stage2;
endmodule

// ---- design/safety_output_test_pulse.sv ----
// four duplicated safety outputs with test pulse diagnosis and AXI4-Lite
`timescale 1ns/1ps
module safety_output_test_pulse #(
   parameter logic [15:0] PULSE_PERIOD_TICKS = safe_out_pkg::PERIOD_TICKS_DEF
) (
   input wire logic ref_clk, // 250 MHz core clock
   input wire logic reset_n, // synchronous reset, active low
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write byte strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire logic torque_off_status_out, // source 1
   input wire logic stop1_status_out, // source 2
   input wire logic stop2_status_out, // source 3
   input wire logic speed_limit1_status_out, // source 4
   input wire logic speed_limit2_status_out, // source 5
   input wire logic speed_limit3_status_out, // source 6
   input wire logic speed_limit4_status_out, // source 7
   input wire logic speed_monitor_status_out, // source 8
   input wire logic standstill_status_out, // source 9
   input wire logic brake_control_status_out, // source 10
   input wire logic startup_done, // start-up diagnosis complete
   input wire logic disable_class_alarm, // alarm of the disabling class
   input wire logic [safe_out_pkg::LEG_COUNT-1:0] legFeedback, // pins
   output logic safe_out_ch1_leg_a, // channel 1 leg A
   output logic safe_out_ch1_leg_b, // channel 1 leg B
   output logic safe_out_ch2_leg_a, // channel 2 leg A
   output logic safe_out_ch2_leg_b, // channel 2 leg B
   output logic safe_out_ch3_leg_a, // channel 3 leg A
   output logic safe_out_ch3_leg_b, // channel 3 leg B
   output logic safe_out_ch4_sink_leg, // channel 4 sinking leg
   output logic safe_out_ch4_source_leg, // channel 4 sourcing leg
   output logic output_fault_alarm, // sticky diagnosis fault alarm
   output logic irq // level interrupt
);
   import safe_out_pkg::*;

   typedef struct packed {
      logic awready;
      logic awHave;
      logic [7:0] awAddr;
      logic wready;
      logic wHave;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [15:0] outSel;
      logic [3:0] pulseEn;
      logic [15:0] offTime;
      logic [IRQ_W-1:0] irqStat;
      logic [IRQ_W-1:0] irqEn;
      logic irq;
      logic [7:0] tickCnt;
      logic [15:0] phase;
      logic [CH_COUNT-1:0] chOn;
      logic [LEG_COUNT-1:0] legOut;
      logic faultAlarm;
      logic alarmPrev;
   } state_t;

   localparam state_t RST_STATE = '{outSel: OUT_SEL_RST,
                                    pulseEn: PULSE_EN_RST,
                                    offTime: OFF_TIME_RST,
                                    irqEn: IRQ_EN_RST,
                                    default: '0};
   localparam logic [15:0] HALF_TICKS = PULSE_PERIOD_TICKS >> 1;
   localparam logic [15:0] LAST_PHASE = PULSE_PERIOD_TICKS - 16'h0001;

   state_t s;
   state_t n;
   logic [LEG_COUNT-1:0] fb;
   logic [SRC_COUNT-1:0] srcVec;
   logic tick;
   logic runOk;
   logic [15:0] offEff;
   logic inA;
   logic inB;
   logic checkA;
   logic checkB;
   logic [CH_COUNT-1:0] on;
   logic [CH_COUNT-1:0] faultEv;
   logic forcedEv;
   logic [IRQ_W-1:0] clrMask;
   logic [31:0] merged;

   feedback_sync u_sync (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .asyncIn(legFeedback),
      .syncOut(fb)
   );

   assign srcVec = {brake_control_status_out, standstill_status_out,
                    speed_monitor_status_out, speed_limit4_status_out,
                    speed_limit3_status_out, speed_limit2_status_out,
                    speed_limit1_status_out, stop2_status_out,
                    stop1_status_out, torque_off_status_out};

   always_comb begin
      n = s;
      clrMask = '0;
      merged = '0;
      on = '0;
      faultEv = '0;
      // 1 us tick and pulse period phase
      tick = (s.tickCnt == TICK_LAST);
      n.tickCnt = tick ? 8'h00 : s.tickCnt + 8'h01;
      if (tick) begin
         n.phase = (s.phase == LAST_PHASE) ? 16'h0000 : s.phase + 16'h0001;
      end
      // write path: address and data in either order
      if (s.awready && s_axi_awvalid) begin
         n.awHave = 1'b1;
         n.awAddr = s_axi_awaddr;
      end
      if (s.wready && s_axi_wvalid) begin
         n.wHave = 1'b1;
         n.wData = s_axi_wdata;
         n.wStrb = s_axi_wstrb;
      end
      if (s.awHave && s.wHave && !s.bvalid) begin
         n.awHave = 1'b0;
         n.wHave = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = RESP_OKAY;
         case (s.awAddr)
            OFS_OUT_SEL: begin
               merged = mergeBytes({16'h0000, s.outSel}, s.wData, s.wStrb);
               n.outSel = merged[15:0];
            end
            OFS_PULSE_EN: begin
               merged = mergeBytes({28'h0, s.pulseEn}, s.wData, s.wStrb);
               n.pulseEn = merged[3:0];
            end
            OFS_OFF_TIME: begin
               merged = mergeBytes({16'h0000, s.offTime}, s.wData, s.wStrb);
               n.offTime = merged[15:0];
            end
            OFS_IRQ_CLR: begin
               merged = mergeBytes(32'h0, s.wData, s.wStrb);
               clrMask = merged[IRQ_W-1:0];
            end
            OFS_IRQ_EN: begin
               merged = mergeBytes({27'h0, s.irqEn}, s.wData, s.wStrb);
               n.irqEn = merged[IRQ_W-1:0];
            end
            OFS_IRQ_STAT, OFS_STATE: begin
               n.bresp = RESP_OKAY;
            end
            default: begin
               n.bresp = RESP_SLVERR;
            end
         endcase
      end
      if (s.bvalid && s_axi_bready) begin
         n.bvalid = 1'b0;
      end
      n.awready = !n.awHave && !n.bvalid;
      n.wready = !n.wHave && !n.bvalid;
      // read path
      if (s.rvalid && s_axi_rready) begin
         n.rvalid = 1'b0;
      end
      if (s.arready && s_axi_arvalid) begin
         n.rvalid = 1'b1;
         n.rresp = RESP_OKAY;
         case (s_axi_araddr)
            OFS_OUT_SEL: n.rdata = {16'h0000, s.outSel};
            OFS_PULSE_EN: n.rdata = {28'h0, s.pulseEn};
            OFS_OFF_TIME: n.rdata = {16'h0000, s.offTime};
            OFS_IRQ_STAT: n.rdata = {27'h0, s.irqStat};
            OFS_IRQ_CLR: n.rdata = 32'h0;
            OFS_IRQ_EN: n.rdata = {27'h0, s.irqEn};
            OFS_STATE: n.rdata = {22'h0, s.faultAlarm, |s.chOn, s.legOut};
            default: begin
               n.rdata = 32'h0;
               n.rresp = RESP_SLVERR;
            end
         endcase
      end
      n.arready = !n.rvalid;
      // channels: held off until start-up ends and on disabling alarm
      runOk = startup_done && !disable_class_alarm; // RULE11 RULE12 RULE13
      // off-time clamped to 1 .. half period minus one so windows never overlap
      if (s.offTime == 16'h0000) begin
         offEff = 16'h0001;
      end else if (s.offTime >= HALF_TICKS) begin
         offEff = HALF_TICKS - 16'h0001;
      end else begin
         offEff = s.offTime; // RULE7
      end
      inA = (s.phase < offEff); // RULE6
      inB = (s.phase >= HALF_TICKS) &&
            (s.phase < HALF_TICKS + offEff); // RULE6
      checkA = tick && (s.phase == offEff - 16'h0001);
      checkB = tick && (s.phase == HALF_TICKS + offEff - 16'h0001);
      for (int c = 0; c < CH_COUNT; c++) begin
         // ch4 leg A sinks and leg B sources; both active high here
         on[c] = runOk && srcPick(s.outSel[SEL_W*c +: SEL_W],
                                  srcVec); // RULE1 RULE4 RULE15
         n.legOut[2*c] = on[c] && !(s.pulseEn[c] && inA); // RULE2 RULE5
         n.legOut[2*c+1] = on[c] && !(s.pulseEn[c] && inB); // RULE3 RULE9
         faultEv[c] = s.chOn[c] && s.pulseEn[c] &&
            ((checkA && !s.legOut[2*c] && s.legOut[2*c+1] &&
              (fb[2*c] || !fb[2*c+1])) ||
             (checkB && s.legOut[2*c] && !s.legOut[2*c+1] &&
              (fb[2*c+1] || !fb[2*c]))); // RULE14
      end
      n.chOn = on;
      n.faultAlarm = s.faultAlarm || (|faultEv); // RULE10
      n.alarmPrev = disable_class_alarm;
      forcedEv = disable_class_alarm && !s.alarmPrev;
      // set wins over a clear in the same cycle
      n.irqStat = (s.irqStat & ~clrMask) | {forcedEv, faultEv};
      n.irq = |(n.irqStat & n.irqEn);
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         s <= RST_STATE;
      end else begin
         s <= n;
      end
   end

   assign s_axi_awready = s.awready;
   assign s_axi_wready = s.wready;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_arready = s.arready;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;
   assign safe_out_ch1_leg_a = s.legOut[0];
   assign safe_out_ch1_leg_b = s.legOut[1];
   assign safe_out_ch2_leg_a = s.legOut[2];
   assign safe_out_ch2_leg_b = s.legOut[3];
   assign safe_out_ch3_leg_a = s.legOut[4];
   assign safe_out_ch3_leg_b = s.legOut[5];
   assign safe_out_ch4_sink_leg = s.legOut[6];
   assign safe_out_ch4_source_leg = s.legOut[7];
   assign output_fault_alarm = s.faultAlarm;
   assign irq = s.irq;

   // checks
   logic [CH_COUNT-1:0] legA;
   logic [CH_COUNT-1:0] legB;
   logic [23:0] offCnt0;
   logic [23:0] pulseCyc;
   always_comb begin
      for (int c = 0; c < CH_COUNT; c++) begin
         legA[c] = s.legOut[2*c];
         legB[c] = s.legOut[2*c+1];
      end
   end
   assign pulseCyc = 24'(offEff) * 24'(TICK_CYC);
   always_ff @(posedge ref_clk) begin
      if (!reset_n || !s.chOn[0] || s.legOut[0]) begin
         offCnt0 <= 24'h000000;
      end else begin
         offCnt0 <= offCnt0 + 24'h000001;
      end
   end

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   property p_startup_off;
      !startup_done |=> (s.legOut == '0);
   endproperty
   a_startup_off: assert property (p_startup_off) // RULE11
      else $error("output on before start-up done");

   property p_disable_off;
      disable_class_alarm |=> (s.legOut == '0);
   endproperty
   a_disable_off: assert property (p_disable_off) // RULE12
      else $error("output on during disabling alarm");

   property p_not_both_off;
      &(~s.chOn | legA | legB);
   endproperty
   a_not_both_off: assert property (p_not_both_off) // RULE6
      else $error("both legs pulsed off together");

   property p_pulse_width;
      (s.chOn[0] && !s.legOut[0]) |-> (offCnt0 < pulseCyc);
   endproperty
   a_pulse_width: assert property (p_pulse_width) // RULE7
      else $error("off-pulse longer than off-time");

   property p_pulse_disabled;
      &(~s.chOn | $past(s.pulseEn) | (legA & legB));
   endproperty
   a_pulse_disabled: assert property (p_pulse_disabled) // RULE9
      else $error("pulse on a channel with pulsing disabled");

   property p_fault_alarm;
      (|faultEv) |=> output_fault_alarm && (s.irqStat[3:0] != 4'h0);
   endproperty
   a_fault_alarm: assert property (p_fault_alarm) // RULE10
      else $error("fault did not raise alarm");

   property p_alarm_sticky;
      output_fault_alarm |=> output_fault_alarm;
   endproperty
   a_alarm_sticky: assert property (p_alarm_sticky) // RULE10
      else $error("fault alarm dropped");

   property p_select_drive;
      (startup_done && !disable_class_alarm && !s.pulseEn[0] &&
       s.outSel[3:0] == SEL_STO && torque_off_status_out) [*2]
      |=> safe_out_ch1_leg_a && safe_out_ch1_leg_b;
   endproperty
   a_select_drive: assert property (p_select_drive) // RULE1 RULE2 RULE13
      else $error("selected source not driven");

   property p_none_off;
      (s.outSel[15:12] == SEL_NONE) |=> !s.legOut[6] && !s.legOut[7];
   endproperty
   a_none_off: assert property (p_none_off) // RULE15
      else $error("unassigned channel driven");

   property p_readback;
      (checkA && s.chOn[0] && s.pulseEn[0] && !s.legOut[0] &&
       s.legOut[1] && fb[0]) |=> output_fault_alarm;
   endproperty
   a_readback: assert property (p_readback) // RULE14
      else $error("stuck-high leg not flagged");

   c_pulse_a: cover property (s.chOn[0] && $fell(s.legOut[0]));
   c_pulse_b: cover property (s.chOn[0] && $fell(s.legOut[1]));
   c_fault: cover property ($rose(output_fault_alarm));
   c_forced_off: cover property (|s.chOn ##1 disable_class_alarm);
endmodule

// ---- tb/leg_load_model.sv ----
// external load model echoing the leg outputs on the read-back pins
`timescale 1ns/1ps
module leg_load_model #(
   parameter int DELAY_NS = 8
) (
   input wire logic [7:0] legDrive, // leg outputs of the block
   input wire logic [7:0] stuckOn, // legs whose wiring is shorted on
   output logic [7:0] legFeedback // read-back pins
);
   // healthy wiring follows the leg after a settling delay
   assign #(DELAY_NS) legFeedback = legDrive | stuckOn;
endmodule

// ---- tb/safety_output_test_pulse_tb_top.sv ----
// bench for the safety output test pulse block
`timescale 1ns/1ps
module safety_output_test_pulse_tb_top;
   import safe_out_pkg::*;
   logic ref_clk, reset_n, awValid, wValid, bReady, arValid, rReady;
   logic awReady, wReady, bValid, arReady, rValid, alarm, irq;
   logic [7:0] awAddr, arAddr, legs, fb, stuck;
   logic [31:0] wData, rData, rd;
   logic [3:0] wStrb;
   logic [1:0] bResp, rResp, rs;
   logic [9:0] srcs, oh;
   logic startDone, offAlarm;
   int miscompares, compares, runA, runB, maxA, maxB, both, other;

   safety_output_test_pulse #(.PULSE_PERIOD_TICKS(16'h0010))
   u_safety_output_test_pulse (
      .ref_clk(ref_clk), .reset_n(reset_n),
      .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
      .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
      .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
      .s_axi_bvalid(bValid), .s_axi_bready(bReady),
      .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
      .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
      .s_axi_rvalid(rValid), .s_axi_rready(rReady),
      .torque_off_status_out(srcs[0]), .stop1_status_out(srcs[1]),
      .stop2_status_out(srcs[2]), .speed_limit1_status_out(srcs[3]),
      .speed_limit2_status_out(srcs[4]), .speed_limit3_status_out(srcs[5]),
      .speed_limit4_status_out(srcs[6]),
      .speed_monitor_status_out(srcs[7]),
      .standstill_status_out(srcs[8]), .brake_control_status_out(srcs[9]),
      .startup_done(startDone), .disable_class_alarm(offAlarm),
      .legFeedback(fb),
      .safe_out_ch1_leg_a(legs[0]), .safe_out_ch1_leg_b(legs[1]),
      .safe_out_ch2_leg_a(legs[2]), .safe_out_ch2_leg_b(legs[3]),
      .safe_out_ch3_leg_a(legs[4]), .safe_out_ch3_leg_b(legs[5]),
      .safe_out_ch4_sink_leg(legs[6]), .safe_out_ch4_source_leg(legs[7]),
      .output_fault_alarm(alarm), .irq(irq)
   );

   leg_load_model u_leg_load_model (
      .legDrive(legs), .stuckOn(stuck), .legFeedback(fb)
   );

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   task automatic test_done();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic hang(input string what);
      miscompares++;
      $display("[FAIL] %s expected answer seen none", what);
      test_done();
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] r);
      int n;
      logic awDone, wDone, bDone;
      awDone = 1'b0;
      wDone = 1'b0;
      bDone = 1'b0;
      n = 0;
      awAddr <= a;
      wData <= d;
      wStrb <= 4'hF;
      awValid <= 1'b1;
      wValid <= 1'b1;
      bReady <= 1'b1;
      while (!bDone) begin
         @(posedge ref_clk);
         n++;
         if (!awDone && awReady) begin
            awDone = 1'b1;
            awValid <= 1'b0;
         end
         if (!wDone && wReady) begin
            wDone = 1'b1;
            wValid <= 1'b0;
         end
         if (bValid) begin
            bDone = 1'b1;
            r = bResp;
            bReady <= 1'b0;
         end
         if (n > 200) hang("write answer");
      end
      @(posedge ref_clk);
   endtask

   task automatic axiRead(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
      int n;
      logic aDone, dDone;
      aDone = 1'b0;
      dDone = 1'b0;
      n = 0;
      arAddr <= a;
      arValid <= 1'b1;
      rReady <= 1'b1;
      while (!dDone) begin
         @(posedge ref_clk);
         n++;
         if (!aDone && arReady) begin
            aDone = 1'b1;
            arValid <= 1'b0;
         end
         if (rValid) begin
            dDone = 1'b1;
            d = rData;
            r = rResp;
            rReady <= 1'b0;
         end
         if (n > 200) hang("read answer");
      end
      @(posedge ref_clk);
   endtask

   initial begin
      miscompares = 0;
      compares = 0;
      reset_n = 1'b0;
      {awValid, wValid, bReady, arValid, rReady} = 5'h00;
      awAddr = 8'h00;
      arAddr = 8'h00;
      wData = 32'h00000000;
      wStrb = 4'h0;
      srcs = 10'h3FF;
      startDone = 1'b0;
      offAlarm = 1'b0;
      stuck = 8'h00;
      cyc(3);
      reset_n <= 1'b1;
      cyc(2);
      // register reset values and an unmapped place
      axiRead(OFS_OUT_SEL, rd, rs);
      check("out_sel reset", rd, 32'h00000000);
      axiRead(OFS_OFF_TIME, rd, rs);
      check("off_time reset", rd, 32'h0000000A);
      axiRead(OFS_PULSE_EN, rd, rs);
      check("pulse_en reset", rd, 32'h00000000);
      axiRead(8'h1C, rd, rs);
      check("unmapped read resp", {30'h0, rs}, {30'h0, RESP_SLVERR});
      check("unmapped read data", rd, 32'h00000000);
      axiWrite(8'h1C, 32'h00000001, rs);
      check("unmapped write resp", {30'h0, rs}, {30'h0, RESP_SLVERR});
      // one source shared by every channel, start-up still running
      axiWrite(OFS_OUT_SEL, 32'h00001111, rs);
      check("out_sel write resp", {30'h0, rs}, {30'h0, RESP_OKAY});
      cyc(3);
      check("legs before start-up", {24'h0, legs}, 32'h0);
      startDone <= 1'b1;
      cyc(3);
      check("legs after start-up", {24'h0, legs}, 32'hFF);
      check("ch4 sink and source", {30'h0, legs[7:6]}, 32'h3);
      // every selection code on channel 1
      for (int c = 0; c < 16; c++) begin
         oh = (c >= 1 && c <= 10) ? 10'(1 << (c - 1)) : 10'h000;
         axiWrite(OFS_OUT_SEL, {20'h00001, 8'h11, 4'(c)}, rs);
         srcs <= ~oh;
         cyc(3);
         check("sel source low", {30'h0, legs[1:0]}, 32'h0);
         srcs <= oh;
         cyc(3);
         check("sel source high", {30'h0, legs[1:0]},
               (oh != 10'h000) ? 32'h3 : 32'h0);
      end
      srcs <= 10'h3FF;
      axiWrite(OFS_OUT_SEL, 32'h00001111, rs);
      // disabling alarm forces all legs off and raises the event
      axiWrite(OFS_IRQ_EN, 32'h00000010, rs);
      offAlarm <= 1'b1;
      cyc(3);
      check("legs under alarm", {24'h0, legs}, 32'h0);
      check("irq forced off", {31'h0, irq}, 32'h1);
      axiRead(OFS_IRQ_STAT, rd, rs);
      check("forced off event", rd & 32'h10, 32'h10);
      offAlarm <= 1'b0;
      axiWrite(OFS_IRQ_CLR, 32'h00000010, rs);
      cyc(3);
      check("irq cleared", {31'h0, irq}, 32'h0);
      check("legs back", {24'h0, legs}, 32'hFF);
      // short off-time so the load ignores the pulses
      axiWrite(OFS_OFF_TIME, 32'h00000002, rs);
      axiWrite(OFS_PULSE_EN, 32'h00000001, rs);
      runA = 0;
      runB = 0;
      maxA = 0;
      maxB = 0;
      both = 0;
      other = 0;
      for (int i = 0; i < 8400; i++) begin
         @(posedge ref_clk);
         if (!legs[0]) runA++;
         else runA = 0;
         if (!legs[1]) runB++;
         else runB = 0;
         if (runA > maxA) maxA = runA;
         if (runB > maxB) maxB = runB;
         if (!legs[0] && !legs[1]) both++;
         if (legs[7:2] !== 6'h3F) other++;
      end
      check("leg a off width", maxA, 32'h000001F4);
      check("leg b off width", maxB, 32'h000001F4);
      check("both legs off", both, 32'h0);
      check("unpulsed channels", other, 32'h0);
      check("no false alarm", {31'h0, alarm}, 32'h0);
      // leg A wiring shorted on: the next leg A pulse must be diagnosed
      axiWrite(OFS_IRQ_EN, 32'h00000001, rs);
      stuck <= 8'h01;
      for (int i = 0; i < 9000 && alarm !== 1'b1; i++) @(posedge ref_clk);
      check("fault alarm", {31'h0, alarm}, 32'h1);
      cyc(3);
      check("fault irq", {31'h0, irq}, 32'h1);
      axiRead(OFS_IRQ_STAT, rd, rs);
      check("fault event ch1", rd & 32'h1, 32'h1);
      axiRead(OFS_STATE, rd, rs);
      check("state alarm bit", rd[STATE_FAULT_BIT], 32'h1);
      test_done();
   end
endmodule
